// File: octal_switch_spi_fault_logic.sv
// serial command, fault latching and shutdown logic of an eight-output load switch
`timescale 1ns/10ps

// Functional notes
// - status word shifts out while command shifts in
// - no fault with detect current gives zeros
// - faulted output returns one in its bit
// - first 16 bits: eight zeros, eight faults
// - longer frames echo earlier received bits unchanged
// - chip-select rise latches last 16 bits
// - only 16 plus multiples of 8 accepted
// - over-temperature turns off that output, sets bit
// - output returns when cool unless commanded off
// - over-voltage forces all off, then restores
// - open-load checked per output while commanded off
// - detect current per output, off after reset
// - detect currents off without logic supply/enable
// - chip-select rise starts open-load blanking timer
// - open-load fault stays latched until read
// - thermal cycling under short repeats automatically
// - short faults reported regardless of detect enable
// - under-voltage turns all off, resets registers
// - low command byte switches outputs on/off
// - high command byte enables detect currents
// - words shifted most significant bit first
// - off open-load reported only with current enabled

module octal_switch_spi_fault_logic #(
    parameter int FAULT_DELAY_CYCLES = switch_pkg::FAULT_DELAY_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic [7:0] i_open_cmp,
    input wire logic [7:0] i_over_temp,
    input wire logic [7:0] i_over_curr,
    input wire logic i_load_supply_ov,
    input wire logic i_load_supply_uv,
    input wire logic i_logic_supply_uv,
    input wire logic i_enable,
    output logic [7:0] o_drive,
    output logic [7:0] o_ol_current,
    output logic [7:0] o_fault
);

    // ------------------------------------------------------------
    // link domain: bit counter, shift register, frame check
    // ------------------------------------------------------------
    logic [4:0] bit_cnt_q; // bits seen in this frame, folds 16..23
    logic [4:0] bit_cnt_d; // count after this edge
    logic [15:0] shift_q; // received bits, newest at bit 0
    logic frame_ok_q; // count so far is 16 plus a multiple of 8
    logic link_rst; // idle select clears the counter
    switch_pkg::status_word_t snap_q; // status frozen for the frame, system domain
    logic out_bit; // bit presented on the serial output

    assign link_rst = i_cs_b | ~i_rst_b;

    // fold the count so any multiple of 8 past 16 lands on 16
    always_comb
    begin
        if (bit_cnt_q == switch_pkg::FRAME_LAST_BIT)
            bit_cnt_d = switch_pkg::FRAME_MIN_BITS;
        else
            bit_cnt_d = bit_cnt_q + 5'h01;
    end

    // counter restarts whenever select is idle; no edge outside frames
    always_ff @(posedge i_sclk or posedge link_rst)
    begin
        if (link_rst)
            bit_cnt_q <= 5'h00;
        else
            bit_cnt_q <= bit_cnt_d;
    end

    // shift in msb first; contents must survive select rising
    always_ff @(posedge i_sclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            shift_q <= switch_pkg::CMD_RST;
        else
            shift_q <= {shift_q[14:0], i_mosi};
    end

    // frame validity as of the last edge, held past select rising
    always_ff @(posedge i_sclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            frame_ok_q <= 1'b0;
        else
            frame_ok_q <= (bit_cnt_d == switch_pkg::FRAME_MIN_BITS);
    end

    // first 16 bits come from the frozen status, later ones echo input
    always_comb
    begin
        if (bit_cnt_q < switch_pkg::FRAME_MIN_BITS)
            out_bit = snap_q[switch_pkg::WORD_MSB_IDX - bit_cnt_q[3:0]];
        else
            out_bit = shift_q[15];
    end

    // output released while select is idle
    assign o_miso = out_bit & ~i_cs_b;
    assign o_miso_oe = ~i_cs_b;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    switch_pkg::fault_ind_t ind_s; // filtered analog indications
    switch_pkg::supply_ind_t sup_s; // filtered supply indications
    logic cs_b_s; // filtered select
    logic cs_b_prev_q; // select one cycle back

    pin_sync3 #(
        .WIDTH(24)
    ) u_sync_ind (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_open_cmp, i_over_temp, i_over_curr}),
        .o_sync(ind_s)
    );

    // select idles high, so it is synchronised inverted to reset to idle
    logic cs_s; // select active, filtered
    pin_sync3 #(
        .WIDTH(5)
    ) u_sync_sup (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_load_supply_ov, i_load_supply_uv, i_logic_supply_uv, i_enable, ~i_cs_b}),
        .o_sync({sup_s, cs_s})
    );
    assign cs_b_s = ~cs_s;

    // edge detect on the filtered select only
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cs_b_prev_q <= 1'b1;
        else
            cs_b_prev_q <= cs_b_s;
    end

    logic cs_fall; // frame begins
    logic cs_rise; // frame ends
    logic pwr_fail; // either supply low or enable removed
    assign cs_fall = cs_b_prev_q & ~cs_b_s;
    assign cs_rise = ~cs_b_prev_q & cs_b_s;
    assign pwr_fail = sup_s.load_uv | sup_s.logic_uv | ~sup_s.enable;

    // ------------------------------------------------------------
    // command latch
    // ------------------------------------------------------------
    switch_pkg::cmd_word_t cmd_q; // latched command

    // link shift register is frozen once select is high, so a plain
    // sample after the synchronised rise is safe
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cmd_q <= switch_pkg::CMD_RST;
        else if (pwr_fail)
            cmd_q <= switch_pkg::CMD_RST;
        else if (cs_rise && frame_ok_q)
            cmd_q <= shift_q;
    end

    // ------------------------------------------------------------
    // open-load blanking timer
    // ------------------------------------------------------------
    localparam int FD_W = $clog2(FAULT_DELAY_CYCLES + 1);
    localparam logic [FD_W-1:0] FD_LAST = FD_W'(FAULT_DELAY_CYCLES - 1);
    switch_pkg::fault_delay_t fd_q; // blanking state
    logic [FD_W-1:0] fd_cnt_q; // cycles since select rise

    // every select rise restarts blanking, even for rejected frames
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            fd_q <= switch_pkg::FD_RUN;
            fd_cnt_q <= '0;
        end
        else if (cs_rise)
        begin
            fd_q <= switch_pkg::FD_RUN;
            fd_cnt_q <= '0;
        end
        else
        begin
            case (fd_q)
                switch_pkg::FD_RUN:
                begin
                    if (fd_cnt_q == FD_LAST)
                        fd_q <= switch_pkg::FD_DONE;
                    else
                        fd_cnt_q <= fd_cnt_q + 1'b1;
                end
                switch_pkg::FD_DONE:
                    fd_cnt_q <= fd_cnt_q;
                default:
                    fd_q <= switch_pkg::FD_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // fault latch and status snapshot
    // ------------------------------------------------------------
    logic [7:0] fault_q; // sticky per output fault
    logic [7:0] open_set; // off-state open load seen
    logic [7:0] on_set; // on-state short seen
    logic fd_done; // comparators may be trusted

    assign fd_done = (fd_q == switch_pkg::FD_DONE);
    // only while commanded off, and only with detect current on
    assign open_set = ~cmd_q.on & cmd_q.ol_en & {8{fd_done}} & ind_s.open_cmp;
    // shorts report whatever the detect current setting
    assign on_set = cmd_q.on & ind_s.over_curr;

    // a read clears, but a set in the same cycle wins
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            fault_q <= switch_pkg::FAULT_RST;
        else if (pwr_fail)
            fault_q <= switch_pkg::FAULT_RST;
        else if (cs_fall)
            fault_q <= open_set | on_set | ind_s.over_temp;
        else
            fault_q <= fault_q | open_set | on_set | ind_s.over_temp;
    end

    // status frozen at frame start; stays put for the whole frame
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            snap_q <= {switch_pkg::STATUS_PAD, switch_pkg::FAULT_RST};
        else if (cs_fall)
            snap_q <= {switch_pkg::STATUS_PAD, fault_q};
    end

    // ------------------------------------------------------------
    // output drive and detect current
    // ------------------------------------------------------------
    logic [7:0] drive_q; // gate command per output
    logic [7:0] ol_cur_q; // detect current source per output

    // thermal shutdown is per output and retries when cool; over-voltage
    // masks all but keeps the latch so outputs come back as commanded
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            drive_q <= 8'h00;
        else if (pwr_fail || sup_s.load_ov)
            drive_q <= 8'h00;
        else
            drive_q <= cmd_q.on & ~ind_s.over_temp;
    end

    // detect currents dropped as soon as supply or enable goes
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ol_cur_q <= 8'h00;
        else if (pwr_fail)
            ol_cur_q <= 8'h00;
        else
            ol_cur_q <= cmd_q.ol_en;
    end

    assign o_drive = drive_q;
    assign o_ol_current = ol_cur_q;
    assign o_fault = fault_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_OV_ALL_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        sup_s.load_ov |=> (o_drive == 8'h00))
        else $error("outputs driven during over-voltage");

    AST_OT_LOCAL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> ((o_drive & $past(ind_s.over_temp)) == 8'h00))
        else $error("hot output still driven");

    AST_OT_RETRY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (!pwr_fail && !sup_s.load_ov) |=> (o_drive == ($past(cmd_q.on) & ~$past(ind_s.over_temp))))
        else $error("output not restored to command");

    AST_UV_RESET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        pwr_fail |=> (cmd_q == switch_pkg::CMD_RST) && (fault_q == 8'h00) ##1 (o_drive == 8'h00))
        else $error("under-voltage did not reset");

    AST_OL_CUR_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(sup_s.enable) |=> (o_ol_current == 8'h00) [*2])
        else $error("detect current on without enable");

    AST_LATCH_AT_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $changed(cmd_q) |-> ($past(cs_rise) && $past(frame_ok_q)) || $past(pwr_fail))
        else $error("command changed outside a good frame end");

    AST_BAD_FRAME: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (cs_rise && !frame_ok_q && !pwr_fail) |=> $stable(cmd_q))
        else $error("rejected frame altered the command");

    AST_BLANKING: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        cs_rise |=> (fd_q == switch_pkg::FD_RUN) [*8])
        else $error("blanking timer not started");

    AST_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        ((~fault_q & $past(fault_q)) != 8'h00) |-> ($past(cs_fall) || $past(pwr_fail)))
        else $error("fault cleared without a read");

    AST_OL_MASK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        1'b1 |=> ((fault_q & ~$past(fault_q) & ~$past(cmd_q.ol_en) & ~$past(cmd_q.on)
        & ~$past(ind_s.over_temp)) == 8'h00))
        else $error("open load reported with detect current off");

    AST_FRAME_16: assert property (@(posedge i_sclk) disable iff (!i_rst_b || i_cs_b)
        (bit_cnt_q == 5'h0F) |=> frame_ok_q ##1 !frame_ok_q)
        else $error("sixteen-bit frame not accepted");

endmodule

// File: switch_pkg.sv
// shared constants, word layouts and state types of the octal switch serial logic
package switch_pkg;

    // ------------------------------------------------------------
    // word geometry
    // ------------------------------------------------------------
    localparam int OUT_N = 8; // number of switched outputs
    localparam int WORD_W = 16; // command and status word width
    localparam logic [4:0] FRAME_MIN_BITS = 5'h10; // shortest accepted frame
    localparam logic [4:0] FRAME_LAST_BIT = 5'h17; // min plus one step of 8, minus one
    localparam logic [3:0] WORD_MSB_IDX = 4'hF; // msb goes out first

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_RST = 16'h0000; // all outputs off, no detect current
    localparam logic [7:0] FAULT_RST = 8'h00; // no fault latched
    localparam logic [7:0] STATUS_PAD = 8'h00; // upper status byte always zero

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 100_000_000; // system clock rate
    localparam int FAULT_DELAY_US = 100; // least open-load blanking after a write
    // least time; whole-MHz rate times the delay, never below one cycle
    localparam int FAULT_DELAY_CYC = (FAULT_DELAY_US * (SYS_CLK_HZ / 1_000_000) + 0) < 1 ? 1 :
        (FAULT_DELAY_US * (SYS_CLK_HZ / 1_000_000));
    localparam int WRITE_GAP_US = 300; // host spacing between writes, host side only

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // command word, msb first on the wire
    typedef struct packed {
        logic [7:0] ol_en; // open-load detect current enable per output
        logic [7:0] on; // output on/off per output
    } cmd_word_t;

    // status word as shifted back to the host
    typedef struct packed {
        logic [7:0] pad; // always zero
        logic [7:0] fault; // per output fault flag
    } status_word_t;

    // analog indications, one bit per output
    typedef struct packed {
        logic [7:0] open_cmp; // off-state drain-source below threshold
        logic [7:0] over_temp; // thermal limit reached
        logic [7:0] over_curr; // short or current limit active
    } fault_ind_t;

    // supply and enable indications
    typedef struct packed {
        logic load_ov; // load supply over-voltage
        logic load_uv; // load supply under-voltage
        logic logic_uv; // logic supply under-voltage
        logic enable; // enable pin high
    } supply_ind_t;

    // open-load blanking timer state
    typedef enum logic [0:0] {
        FD_RUN,
        FD_DONE
    } fault_delay_t;

endpackage

// File: pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps

module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // ------------------------------------------------------------
    // flop chain
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_q; // first stage, read only by second
    logic [WIDTH-1:0] s2_q; // second stage
    logic [WIDTH-1:0] s3_q; // third stage
    logic [WIDTH-1:0] out_q; // filtered value

    // capture chain
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree, per bit
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_ff @(posedge i_sys_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    out_q[gi] <= 1'b0;
                else if (s2_q[gi] == s3_q[gi])
                    out_q[gi] <= s2_q[gi];
            end
        end
    endgenerate

    assign o_sync = out_q;

endmodule

// File: spi_host_model.sv
// host-side serial master model that frames command words onto the link
`timescale 1ns/10ps

module spi_host_model #(
    parameter int GAP_NS = 400 // write spacing, scaled down with the short blanking timer
) (
    output logic o_sclk,
    output logic o_cs_b,
    output logic o_mosi,
    input wire logic i_miso
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    // link clock stands still outside frames
    initial
    begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_mosi = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame of n bits on a 12 ns link clock
    // ------------------------------------------------------------
    // spacing comes first so the caller regains control right at select rise
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        int i;
        rx = '0;
        #GAP_NS;
        o_cs_b <= 1'b0;
        #100; // covers setup and the status snapshot crossing
        for (i = n - 1; i >= 0; i--)
        begin
            o_mosi <= tx[i]; // msb first
            #6;
            rx = {rx[30:0], i_miso}; // taken at the rising edge, before the shift
            o_sclk <= 1'b1;
            #6;
            o_sclk <= 1'b0;
        end
        #6;
        o_cs_b <= 1'b1;
        o_mosi <= ~o_mosi; // released line shows no stale value
    endtask
endmodule

// File: octal_switch_spi_fault_logic_tb.sv
// self-checking bench of the octal switch serial and fault logic
`timescale 1ns/10ps

module octal_switch_spi_fault_logic_tb;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic sys_clk; // 100 MHz
    logic rst_b;
    logic sclk, cs_b, mosi, miso, miso_oe;
    logic [7:0] cmp, ot, oc, drive, ol_cur, fault;
    logic ov, luv, vuv, en;
    logic [31:0] rx; // word seen by the host
    int err_total = 0;
    int check_count = 0;
    int bad[5] = '{8, 15, 17, 20, 31}; // refused frame lengths

    octal_switch_spi_fault_logic #(.FAULT_DELAY_CYCLES(20)) uut (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
        .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_open_cmp(cmp),
        .i_over_temp(ot), .i_over_curr(oc), .i_load_supply_ov(ov),
        .i_load_supply_uv(luv), .i_logic_supply_uv(vuv), .i_enable(en),
        .o_drive(drive), .o_ol_current(ol_cur), .o_fault(fault));

    spi_host_model host (.o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi), .i_miso(miso));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // one verdict for every exit path
    task automatic complete_run();
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // seen is copied when the task is called; only the compare waits 1 ns
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        #1;
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // frame then realign to the system clock
    task automatic frame(input int n, input logic [31:0] tx);
        host.xfer(n, tx, rx);
        @(posedge sys_clk);
    endtask

    // hang guard
    initial
    begin
        cyc(100000);
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        {cmp, ot, oc} = '0;
        {ov, luv, vuv} = '0;
        en = 1'b1; // enable raised before release
        cyc(7);
        check(drive, 32'h0000_0000);
        check(ol_cur, 32'h0000_0000);
        // release lands on a clock edge, after eight edges in reset
        cyc(1);
        rst_b <= 1'b1;
        cyc(8);
        check({miso, miso_oe}, 32'h0000_0000);
        // integrity frame: zeros and faults, then the echo
        frame(32, 32'h1234_0F3C);
        check(rx, 32'h0000_1234);
        cyc(8);
        check(drive, 32'h0000_003C);
        check(ol_cur, 32'h0000_000F);
        // wrong lengths leave the command alone
        foreach (bad[i])
        begin
            frame(bad[i], 32'hFFFF_FFFF);
            cyc(8);
            check(drive, 32'h0000_003C);
        end
        // output enabled and showing the zero pad before the first clock
        fork
            frame(24, 32'h00AB_00C3);
            begin
                cyc(50);
                check({miso, miso_oe}, 32'h0000_0001);
            end
        join
        check(rx, 32'h0000_00AB);
        cyc(8);
        check(drive, 32'h0000_00C3);
        check({miso, miso_oe}, 32'h0000_0000);
        // off-state open load: blanked, then latched until read
        frame(16, 32'h0000_FF00);
        cmp <= 8'h01;
        cyc(10);
        check(fault, 32'h0000_0000);
        cyc(40);
        cmp <= 8'h00;
        check(fault, 32'h0000_0001);
        cyc(10);
        check(fault, 32'h0000_0001);
        frame(16, 32'h0000_FF00);
        check(rx, 32'h0000_0001);
        frame(16, 32'h0000_0000);
        check(rx, 32'h0000_0000);
        // open load hidden with detect current off
        cyc(1);
        cmp <= 8'hFF;
        cyc(50);
        cmp <= 8'h00;
        check(fault, 32'h0000_0000);
        frame(16, 32'h0000_0003);
        check(rx, 32'h0000_0000);
        // thermal shutdown of one output and automatic return
        cyc(8);
        ot <= 8'h01;
        check(drive, 32'h0000_0003);
        cyc(8);
        ot <= 8'h00;
        check(drive, 32'h0000_0002);
        check(fault, 32'h0000_0001);
        cyc(8);
        oc <= 8'h02;
        check(drive, 32'h0000_0003);
        cyc(8);
        oc <= 8'h00;
        frame(16, 32'h0000_0002);
        check(rx, 32'h0000_0003);
        // cooling does not override a command to stay off
        cyc(1);
        ot <= 8'h01;
        frame(16, 32'h0000_0002);
        ot <= 8'h00;
        cyc(10);
        ov <= 1'b1;
        check(drive, 32'h0000_0002);
        // over-voltage masks all outputs, command kept
        cyc(8);
        ov <= 1'b0;
        check(drive, 32'h0000_0000);
        cyc(8);
        check(drive, 32'h0000_0002);
        // enable loss drops detect currents and the command
        frame(16, 32'h0000_FF02);
        cyc(8);
        en <= 1'b0;
        check(ol_cur, 32'h0000_00FF);
        cyc(8);
        en <= 1'b1;
        check(ol_cur, 32'h0000_0000);
        cyc(8);
        check(drive, 32'h0000_0000);
        // either supply low turns everything off, then a clean restart
        for (int i = 0; i < 2; i++)
        begin
            frame(16, 32'h0000_0F01);
            cyc(8);
            {luv, vuv} <= 2'b01 << i;
            check({ol_cur, drive}, 32'h0000_0F01);
            cyc(8);
            {luv, vuv} <= 2'b00;
            check({ol_cur, drive}, 32'h0000_0000);
            cyc(10);
            check({ol_cur, drive}, 32'h0000_0000);
        end
        complete_run();
    end
endmodule
